// ### common/spi_port_params.svh
// constants of the four-wire serial port
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

`define SPI_WORD_W        32
`define SPI_BIT_CNT_W     6
`define SPI_RATE_W        16
`define SPI_SEL_N         4
`define SPI_LEN_8         2'h0
`define SPI_LEN_16        2'h1
`define SPI_LEN_32        2'h2
`define SPI_LEN_8_BITS    6'h08
`define SPI_LEN_16_BITS   6'h10
`define SPI_LEN_32_BITS   6'h20
`define SPI_MIN_HALF      16'h0005
`define SPI_SEL_IDLE      4'hf
`define SPI_WORD_RESET    32'h0000_0000

`endif

// ### common/spi_port_pkg.sv
// types shared by the serial port modules
package spi_port_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_TRAIL = 2'b10,
        ST_DONE  = 2'b11
    } master_state_e;

    typedef struct packed {
        logic        master_enable;
        logic        multi_master_en;
        logic        open_drain_en;
        logic        cpol;
        logic        cpha;
        logic        lsb_first;
        logic [1:0]  word_len;
        logic        sign_extend;
        logic        miso_output_disable;
        logic [3:0]  select_enable;
        logic [15:0] port_b_bit_rate_setting;
    } port_cfg_s;

    typedef struct packed {
        logic        serial_clock_out;
        logic        clock_pin_buffer_enable;
        logic        mosi_out;
        logic        master_out_pin_buffer_enable;
        logic        miso_out;
        logic        master_in_pin_buffer_enable;
        logic [3:0]  slave_select_outputs;
        logic [3:0]  select_pin_buffer_enable;
    } port_pins_s;

endpackage

// ### logic/serial_slave.sv
// slave-role shifter running on the incoming serial clock
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_params.svh"
module serial_slave
    import spi_port_pkg::*;
(
    input  wire logic        link_clock, // serial clock pin
    input  wire logic        select_n,   // slave select, low = selected
    input  wire logic        enable,     // slave role active
    input  wire logic        cpol,       // idle clock level
    input  wire logic        cpha,       // sample on trailing edge
    input  wire logic        lsb_first,  // bit order
    input  wire logic [5:0]  word_bits,  // bits per word
    input  wire logic        mosi_in,    // data from master
    input  wire logic [31:0] tx_word,    // quasi-static word to send
    output var  logic        miso_bit,   // bit presented on miso
    output var  logic [31:0] rx_word,    // last complete word
    output var  logic        done_tgl    // toggles per complete word
);
    typedef struct packed {
        logic [31:0] sr;
        logic [31:0] hold;
        logic [5:0]  cnt;
        logic        tgl;
    } slave_s;

    slave_s st_r;
    slave_s st_nxt;
    logic   sample_clk;
    logic   frame_clr;
    logic [5:0] idx;

    // rising edge of this clock is the sample edge in all four modes
    assign sample_clk = link_clock ^ cpol ^ cpha;
    // selection ending restarts the bit count; no edge is relied on outside a frame
    assign frame_clr  = select_n | ~enable;

    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.cnt = st_r.cnt + 6'h01;
        if (lsb_first)
        begin
            st_nxt.sr = (st_r.sr >> 1) | ({31'h0, mosi_in} << (word_bits - 6'h01));
        end
        else
        begin
            st_nxt.sr = {st_r.sr[30:0], mosi_in};
        end
        if (st_r.cnt == word_bits - 6'h01)
        begin
            st_nxt.cnt  = 6'h00;
            st_nxt.hold = st_nxt.sr;
            st_nxt.tgl  = ~st_r.tgl;
        end
    end

    always_ff @(posedge sample_clk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            st_r.cnt <= 6'h00;
            if (!enable)
            begin
                st_r.tgl <= 1'b0;
            end
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // the outgoing bit moves right after a sample edge; the master samples
    // a full serial period later, so this margin is that full period
    assign idx      = lsb_first ? st_r.cnt : (word_bits - 6'h01 - st_r.cnt);
    assign miso_bit = tx_word[idx[4:0]];
    assign rx_word  = st_r.hold;
    assign done_tgl = st_r.tgl;
endmodule
`default_nettype wire

// ### logic/spi_port.sv
// four-wire serial port: master engine, slave front end and pin buffers
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_params.svh"
module spi_port
    import spi_port_pkg::*;
(
    input  wire logic        clock,                // peripheral clock
    input  wire logic        rst_n,                // synchronous reset
    input  wire port_cfg_s   cfg,                  // port configuration
    input  wire logic        fault_clear,          // clears mode fault
    input  wire logic        rx_clear,             // clears overflow flag
    input  wire logic [31:0] core_tx_data,         // core write data
    input  wire logic        core_tx_valid,        // core write request
    output var  logic        core_tx_ready,        // core write accepted
    input  wire logic [31:0] dma_tx_data,          // dma write data
    input  wire logic        dma_tx_valid,         // dma write request
    output var  logic        dma_tx_ready,         // dma write accepted
    output var  logic [31:0] rx_data,              // receive buffer
    output var  logic        rx_valid,             // receive buffer full
    input  wire logic        rx_ack,               // receive buffer read
    input  wire logic        port_b_serial_clock,  // serial clock pin in
    input  wire logic        slave_select_in,      // select pin, low active
    input  wire logic        mosi_in,              // mosi pin in
    input  wire logic        miso_in,              // miso pin in
    output var  port_pins_s  pins,                 // pin outputs and enables
    output var  logic        busy,                 // master transfer in progress
    output var  logic        master_active,        // port acting as master
    output var  logic        mode_fault,           // multi-master fault
    output var  logic        rx_overflow           // word lost, buffer full
);
    typedef struct packed {
        master_state_e st;
        logic [15:0]   half_cnt;
        logic [5:0]    bit_cnt;
        logic [31:0]   tx_sr;
        logic [31:0]   rx_sr;
        logic          sclk;
        logic          mosi;
        logic [3:0]    sel;
        logic [31:0]   tx_buf;
        logic          tx_full;
        logic [31:0]   rx_buf;
        logic          rx_full;
        logic          ovf;
        logic          fault;
        logic          master;
        logic [31:0]   slave_tx;
        logic          tgl_seen;
    } port_s;

    port_s       st_r;
    port_s       st_nxt;
    logic        sel_n_s;
    logic        miso_s;
    logic        tgl_s;
    logic [5:0]  word_bits;
    logic [15:0] half_period;
    logic        slave_on;
    logic        slave_miso;
    logic [31:0] slave_rx;
    logic        slave_tgl;
    logic        take_dma;
    logic        take_core;
    logic        load_word;

    // pin inputs seen by the peripheral clock
    sync3 #(.W(2)) u_pin_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({slave_select_in, miso_in}),
        .init_val (2'b10),
        .sync_out ({sel_n_s, miso_s})
    );

    // word-complete toggle coming back from the serial clock domain
    sync3 #(.W(1)) u_tgl_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (slave_tgl),
        .init_val (1'b0),
        .sync_out (tgl_s)
    );

    assign slave_on = ~st_r.master & ~cfg.master_enable;

    serial_slave u_slave (
        .link_clock (port_b_serial_clock),
        .select_n   (slave_select_in),
        .enable     (slave_on),
        .cpol       (cfg.cpol),
        .cpha       (cfg.cpha),
        .lsb_first  (cfg.lsb_first),
        .word_bits  (word_bits),
        .mosi_in    (mosi_in),
        .tx_word    (st_r.slave_tx),
        .miso_bit   (slave_miso),
        .rx_word    (slave_rx),
        .done_tgl   (slave_tgl)
    );

    always_comb
    begin
        unique case (cfg.word_len)
            `SPI_LEN_8:  word_bits = `SPI_LEN_8_BITS;
            `SPI_LEN_16: word_bits = `SPI_LEN_16_BITS;
            default:     word_bits = `SPI_LEN_32_BITS;
        endcase
    end

    // the miso synchroniser costs four clocks, so a half period of four
    // clocks or less would sample stale data
    assign half_period = (cfg.port_b_bit_rate_setting < `SPI_MIN_HALF) ?
                         `SPI_MIN_HALF : cfg.port_b_bit_rate_setting;

    // dma wins a simultaneous write; both paths share the one buffer
    assign take_dma  = dma_tx_valid & ~st_r.tx_full;
    assign take_core = core_tx_valid & ~st_r.tx_full & ~dma_tx_valid;
    assign dma_tx_ready  = ~st_r.tx_full;
    assign core_tx_ready = ~st_r.tx_full & ~dma_tx_valid;

    function automatic logic [31:0] fit_word(input logic [31:0] w,
                                             input logic [5:0]  n,
                                             input logic        sx);
        logic [31:0] mask;
        logic        top;
        mask = 32'hffff_ffff >> (6'h20 - n);
        top  = w[n[4:0] - 5'h01];
        fit_word = (w & mask) | ((sx & top) ? ~mask : 32'h0000_0000);
    endfunction

    function automatic logic [31:0] rx_shift(input logic [31:0] sr,
                                             input logic        b,
                                             input logic [5:0]  n,
                                             input logic        lsb);
        if (lsb)
        begin
            rx_shift = (sr >> 1) | ({31'h0, b} << (n - 6'h01));
        end
        else
        begin
            rx_shift = {sr[30:0], b};
        end
    endfunction

    function automatic logic out_bit(input logic [31:0] sr,
                                     input logic [5:0]  n,
                                     input logic        lsb);
        logic [5:0] i;
        i       = lsb ? 6'h00 : (n - 6'h01);
        out_bit = sr[i[4:0]];
    endfunction

    always_comb
    begin
        st_nxt    = st_r;
        load_word = 1'b0;

        // transmit buffer fill from either source
        if (take_dma)
        begin
            st_nxt.tx_buf  = dma_tx_data;
            st_nxt.tx_full = 1'b1;
        end
        else if (take_core)
        begin
            st_nxt.tx_buf  = core_tx_data;
            st_nxt.tx_full = 1'b1;
        end

        if (rx_ack)
        begin
            st_nxt.rx_full = 1'b0;
        end
        if (rx_clear)
        begin
            st_nxt.ovf = 1'b0;
        end
        if (fault_clear)
        begin
            st_nxt.fault = 1'b0;
        end

        // role follows the enable, but a fault holds the port off the bus
        // until software clears the fault with fault_clear
        if (!cfg.master_enable)
        begin
            st_nxt.master = 1'b0;
        end
        else if (!st_r.fault && st_r.st == ST_IDLE)
        begin
            st_nxt.master = 1'b1;
        end

        if (st_r.master && cfg.multi_master_en && !sel_n_s)
        begin
            st_nxt.fault  = 1'b1;
            st_nxt.master = 1'b0;
            st_nxt.st     = ST_IDLE;
            st_nxt.sel    = `SPI_SEL_IDLE;
            st_nxt.sclk   = cfg.cpol;
        end
        else
        begin
            unique case (st_r.st)
                ST_IDLE:
                begin
                    st_nxt.sclk = cfg.cpol;
                    if (st_r.master && st_r.tx_full)
                    begin
                        load_word       = 1'b1;
                        st_nxt.tx_sr    = st_r.tx_buf;
                        st_nxt.tx_full  = 1'b0;
                        st_nxt.mosi     = out_bit(st_r.tx_buf, word_bits, cfg.lsb_first);
                        st_nxt.sel      = ~cfg.select_enable;
                        st_nxt.bit_cnt  = 6'h00;
                        st_nxt.rx_sr    = 32'h0000_0000;
                        st_nxt.half_cnt = 16'h0001;
                        st_nxt.st       = ST_LEAD;
                    end
                end
                ST_LEAD:
                begin
                    st_nxt.half_cnt = st_r.half_cnt + 16'h0001;
                    if (st_r.half_cnt == half_period)
                    begin
                        st_nxt.half_cnt = 16'h0001;
                        st_nxt.sclk     = ~cfg.cpol;
                        st_nxt.st       = ST_TRAIL;
                        if (!cfg.cpha)
                        begin
                            st_nxt.rx_sr = rx_shift(st_r.rx_sr, miso_s, word_bits,
                                                    cfg.lsb_first);
                        end
                        else if (st_r.bit_cnt != 6'h00)
                        begin
                            st_nxt.tx_sr = cfg.lsb_first ? (st_r.tx_sr >> 1) :
                                                           (st_r.tx_sr << 1);
                            st_nxt.mosi  = out_bit(st_nxt.tx_sr, word_bits,
                                                   cfg.lsb_first);
                        end
                    end
                end
                ST_TRAIL:
                begin
                    st_nxt.half_cnt = st_r.half_cnt + 16'h0001;
                    if (st_r.half_cnt == half_period)
                    begin
                        st_nxt.half_cnt = 16'h0001;
                        st_nxt.sclk     = cfg.cpol;
                        st_nxt.bit_cnt  = st_r.bit_cnt + 6'h01;
                        st_nxt.st       = (st_r.bit_cnt == word_bits - 6'h01) ?
                                          ST_DONE : ST_LEAD;
                        if (cfg.cpha)
                        begin
                            st_nxt.rx_sr = rx_shift(st_r.rx_sr, miso_s, word_bits,
                                                    cfg.lsb_first);
                        end
                        else
                        begin
                            st_nxt.tx_sr = cfg.lsb_first ? (st_r.tx_sr >> 1) :
                                                           (st_r.tx_sr << 1);
                            st_nxt.mosi  = out_bit(st_nxt.tx_sr, word_bits,
                                                   cfg.lsb_first);
                        end
                    end
                end
                ST_DONE:
                begin
                    // hold selects a final half period before release
                    st_nxt.half_cnt = st_r.half_cnt + 16'h0001;
                    if (st_r.half_cnt == half_period)
                    begin
                        st_nxt.sel = `SPI_SEL_IDLE;
                        st_nxt.st  = ST_IDLE;
                        st_nxt.rx_buf = fit_word(st_r.rx_sr, word_bits,
                                                 cfg.sign_extend);
                        st_nxt.rx_full = 1'b1;
                        if (st_r.rx_full && !rx_ack)
                        begin
                            st_nxt.ovf = 1'b1;
                        end
                    end
                end
            endcase
        end

        // slave side: a completed word shows up as a toggle change
        if (tgl_s != st_r.tgl_seen)
        begin
            st_nxt.tgl_seen = tgl_s;
            st_nxt.rx_buf   = fit_word(slave_rx, word_bits, cfg.sign_extend);
            st_nxt.rx_full  = 1'b1;
            if (st_r.rx_full && !rx_ack)
            begin
                st_nxt.ovf = 1'b1;
            end
            if (st_r.tx_full && !load_word)
            begin
                // limitation: the new word must settle before the next
                // word's first bit, at least five clocks into the word
                st_nxt.slave_tx = st_r.tx_buf;
                st_nxt.tx_full  = 1'b0;
            end
        end
        else if (slave_on && sel_n_s && st_r.tx_full && !load_word)
        begin
            st_nxt.slave_tx = st_r.tx_buf;
            st_nxt.tx_full  = 1'b0;
        end

        // a write is taken only while the buffer is empty, so it never meets a consume in the same cycle
        if (take_dma)
        begin
            st_nxt.tx_buf  = dma_tx_data;
            st_nxt.tx_full = 1'b1;
        end
        else if (take_core)
        begin
            st_nxt.tx_buf  = core_tx_data;
            st_nxt.tx_full = 1'b1;
        end

        if (!rst_n)
        begin
            st_nxt          = '0;
            st_nxt.st       = ST_IDLE;
            st_nxt.sel      = `SPI_SEL_IDLE;
            st_nxt.tx_buf   = `SPI_WORD_RESET;
            st_nxt.rx_buf   = `SPI_WORD_RESET;
            st_nxt.slave_tx = `SPI_WORD_RESET;
        end
    end

    always_ff @(posedge clock)
    begin
        st_r <= st_nxt;
    end

    // pin drivers: clock, mosi and select buffers open only in master role; in open-drain
    // mode only while pulling low so a second master cannot be shorted
    always_comb
    begin
        pins.serial_clock_out             = st_r.sclk;
        pins.mosi_out                     = st_r.mosi;
        pins.slave_select_outputs         = st_r.sel;
        pins.clock_pin_buffer_enable      = st_r.master &
                                            (~cfg.open_drain_en | ~st_r.sclk);
        pins.master_out_pin_buffer_enable = st_r.master &
                                            (~cfg.open_drain_en | ~st_r.mosi);
        for (int i = 0; i < `SPI_SEL_N; i++)
        begin
            pins.select_pin_buffer_enable[i] = st_r.master &
                                               (~cfg.open_drain_en | ~st_r.sel[i]);
        end
        // miso comes only from the slave shifter, never from mosi
        pins.miso_out                     = slave_miso;
        pins.master_in_pin_buffer_enable  = slave_on & ~slave_select_in &
                                            ~cfg.miso_output_disable &
                                            (~cfg.open_drain_en | ~slave_miso);
    end

    assign busy          = (st_r.st != ST_IDLE);
    assign master_active = st_r.master;
    assign mode_fault    = st_r.fault;
    assign rx_overflow   = st_r.ovf;
    assign rx_data       = st_r.rx_buf;
    assign rx_valid      = st_r.rx_full;
endmodule
`default_nettype wire

// ### logic/sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
    parameter int W = 1
) (
    input  wire logic         clock,   // destination clock
    input  wire logic         rst_n,   // synchronous reset, active low
    input  wire logic [W-1:0] async_in, // foreign-domain level
    input  wire logic [W-1:0] init_val, // value shown after reset
    output var  logic [W-1:0] sync_out  // filtered level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // only accept a change once two settled stages agree
        if (st_r.s2 == st_r.s3)
        begin
            st_nxt.out = st_r.s3;
        end
        if (!rst_n)
        begin
            st_nxt = {4{init_val}};
        end
    end

    always_ff @(posedge clock)
    begin
        st_r <= st_nxt;
    end

    assign sync_out = st_r.out;
endmodule
`default_nettype wire

// ### tb/spi_port_pin_interface_bench.sv
// bench for the serial port pin behaviour
`timescale 1ns/1ps
`default_nettype none
module spi_port_pin_interface_bench
    import spi_port_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    port_cfg_s   cfg = '0;
    logic        fault_clear = 1'b0;
    logic        rx_ack = 1'b0;
    logic        core_tx_valid = 1'b0;
    logic        dma_tx_valid = 1'b0;
    logic        link_clk = 1'b0;
    logic        sel_in = 1'b1;
    logic        mosi_in = 1'b0;
    logic        core_tx_ready, dma_tx_ready, rx_valid, master_active, mode_fault, miso_w;
    logic [31:0] core_tx_data = 32'h0, dma_tx_data = 32'h0, slave_word = 32'h0;
    logic [31:0] rx_data, prx, w, seed = 32'hf96e69e1;
    logic [63:0] e, exp_q[$];
    port_pins_s  pins;
    int          num_errors = 0;
    int          n_tests = 0;
    int          k;
    always #25 clock = ~clock;
    spi_port dut_u (.clock, .rst_n, .cfg, .fault_clear, .rx_clear(1'b0), .core_tx_data,
        .core_tx_valid, .core_tx_ready, .dma_tx_data, .dma_tx_valid, .dma_tx_ready, .rx_data,
        .rx_valid, .rx_ack, .port_b_serial_clock(link_clk), .slave_select_in(sel_in),
        .mosi_in, .miso_in(miso_w), .pins, .busy(), .master_active, .mode_fault,
        .rx_overflow());
    spi_slave_model peer_u (.sclk(pins.serial_clock_out), .sel_n(&pins.slave_select_outputs),
        .mosi(pins.mosi_out), .cpol(cfg.cpol), .cpha(cfg.cpha), .lsb(cfg.lsb_first),
        .bits(6'h08 << cfg.word_len), .tx(slave_word), .miso(miso_w), .rx(prx));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic stuck();
        num_errors++;
        results();
    endtask
    task automatic send(input logic [31:0] d, input logic dma);
        logic [31:0] m;
        m = 32'((64'h1 << (8 << cfg.word_len)) - 64'h1);
        exp_q.push_back({d & m, slave_word & m});
        core_tx_data = d;
        dma_tx_data = d;
        core_tx_valid = !dma;
        dma_tx_valid = dma;
        for (k = 0; k < 3000 && !(dma ? dma_tx_ready : core_tx_ready); k++)
            @(negedge clock);
        if (k == 3000) stuck();
        @(negedge clock);
        core_tx_valid = 1'b0;
        dma_tx_valid = 1'b0;
        @(negedge clock);
    endtask
    task automatic drain();
        for (k = 0; k < 9000 && exp_q.size() != 0; k++)
            @(negedge clock);
        if (k == 9000) stuck();
    endtask
    // oldest note against each received word; a word with no note never matches
    always @(negedge clock)
    begin
        rx_ack <= rx_valid;
        if (rx_valid && !rx_ack)
        begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 64'hx;
            check(rx_data, e[31:0]);
            if (cfg.master_enable) check(prx, e[63:32]);
        end
    end
    initial
    begin
        cfg.master_enable = 1'b1;
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        for (int i = 0; i < 4; i++)
        begin
            cfg.cpol = i[1];
            cfg.cpha = i[0];
            cfg.lsb_first = i[0];
            cfg.word_len = 2'(i % 3);
            cfg.select_enable = 4'h1 << i;
            cfg.port_b_bit_rate_setting = 16'(i + 3);
            slave_word = rnd();
            send(rnd(), i[0]);
            send(rnd(), !i[0]);
            drain();
            $display("mode %0d done", i);
        end
        cfg.multi_master_en = 1'b1;
        sel_in = 1'b0;
        for (k = 0; k < 20 && mode_fault !== 1'b1; k++)
            @(negedge clock);
        if (k == 20) stuck();
        check(32'(master_active), 32'h0);
        check(32'(pins.clock_pin_buffer_enable), 32'h0);
        sel_in = 1'b1;
        fault_clear = 1'b1;
        @(negedge clock);
        fault_clear = 1'b0;
        cfg.multi_master_en = 1'b0;
        cfg = '0;
        $display("fault done");
        repeat (4) @(negedge clock);
        w = rnd();
        exp_q.push_back({32'h0, 24'h0, w[7:0]});
        #7 sel_in = 1'b0;
        for (k = 7; k >= 0; k--)
        begin
            mosi_in = w[k];
            #6 link_clk = 1'b1;
            #6 link_clk = 1'b0;
        end
        check(32'(pins.master_in_pin_buffer_enable), 32'h1);
        sel_in = 1'b1;
        cfg.miso_output_disable = 1'b1;
        repeat (16) #6 link_clk = ~link_clk;
        drain();
        repeat (10) @(negedge clock);
        $display("slave done");
        results();
    end
endmodule
`default_nettype wire

// ### tb/spi_port_properties.sv
// pin-level assertions for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_params.svh"
module spi_port_properties
    import spi_port_pkg::*;
(
    input wire logic       clock,           // clock
    input wire logic       rst_n,           // reset
    input wire port_cfg_s  cfg,             // config
    input wire logic       slave_select_in, // select pin
    input wire logic       dma_tx_valid,    // dma request
    input wire logic       core_tx_ready,   // core ready
    input wire port_pins_s pins,            // pin outputs
    input wire logic       master_active,   // master role
    input wire logic       mode_fault       // fault flag
);
    logic [5:0] edges_r;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // rising clock edges inside one select window; a window ends idle in either polarity
    always_ff @(posedge clock)
        if (!rst_n || pins.slave_select_outputs == `SPI_SEL_IDLE)
            edges_r <= 6'h00;
        else if ($rose(pins.serial_clock_out))
            edges_r <= edges_r + 6'h01;
    sequence word_end;
        $rose(pins.slave_select_outputs == `SPI_SEL_IDLE) && !mode_fault;
    endsequence
    a_enables_master:
        assert property (!master_active |-> {pins.clock_pin_buffer_enable,
            pins.master_out_pin_buffer_enable, pins.select_pin_buffer_enable} == 6'h00)
        else $error("enable outside master");
    a_select_pattern:
        assert property (pins.slave_select_outputs != `SPI_SEL_IDLE
            |-> pins.slave_select_outputs == ~cfg.select_enable)
        else $error("bad select pattern");
    a_clock_count:
        assert property (word_end |-> edges_r == (6'h08 << cfg.word_len))
        else $error("bad clock count");
    a_fault_cause:
        assert property ($rose(mode_fault) |->
            cfg.multi_master_en && $past(slave_select_in, 2) == 1'b0)
        else $error("fault without cause");
    a_fault_drop:
        assert property (mode_fault ##1 mode_fault |-> !master_active)
        else $error("master kept after fault");
    a_miso_release:
        assert property (slave_select_in [*5] |-> !pins.master_in_pin_buffer_enable)
        else $error("miso driven while deselected");
    a_miso_disable:
        assert property (cfg.miso_output_disable [*2] |-> !pins.master_in_pin_buffer_enable)
        else $error("miso driven while disabled");
    a_dma_first:
        assert property (dma_tx_valid |-> !core_tx_ready)
        else $error("core taken beside dma");
endmodule
bind spi_port spi_port_properties chk_u (.clock, .rst_n, .cfg, .slave_select_in,
    .dma_tx_valid, .core_tx_ready, .pins, .master_active, .mode_fault);
`default_nettype wire

// ### tb/spi_slave_model.sv
// external slave answering the port in master role
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
    input  wire logic        sclk,  // clock
    input  wire logic        sel_n, // select
    input  wire logic        mosi,  // data in
    input  wire logic        cpol,  // idle level
    input  wire logic        cpha,  // phase
    input  wire logic        lsb,   // order
    input  wire logic [5:0]  bits,  // length
    input  wire logic [31:0] tx,    // reply word
    output var  logic        miso,  // reply line
    output var  logic [31:0] rx     // captured word
);
    int n = 0;
    function automatic int pos(input int j);
        return lsb ? j : int'(bits) - 1 - j;
    endfunction
    initial miso = 1'b0;
    initial rx = 32'h0;
    always @(negedge sel_n)
    begin
        n = 0;
        rx = 32'h0;
        miso = tx[pos(0)];
    end
    // released line shows the inverse so a stale sample is caught
    always @(posedge sel_n) miso = ~miso;
    always @(sclk)
        if (!sel_n && (sclk ^ cpol ^ cpha))
        begin
            rx[pos(n)] = mosi;
            n = n + 1;
            if (n < int'(bits)) miso = tx[pos(n)];
        end
endmodule
`default_nettype wire
